// [common/wake_pkg.sv]
// Package for the wake event output block: register map, field positions, timing.
// Assumes a 25 MHz system clock and byte-addressed register port.
package wake_pkg;
	// Register offsets (byte addresses)
	localparam logic [8:0] PWR_MGMT_OFS = 9'h084; // Power management control
	localparam logic [8:0] HARDWARE_CONFIG_REG_OFS = 9'h074; // Hardware config, ready mirror
	localparam logic [8:0] IRQ_STS_OFS = 9'h058; // Interrupt status
	localparam logic [8:0] IRQ_MASK_OFS = 9'h05c; // Interrupt mask
	localparam logic [8:0] CTRL_OFS = 9'h0a0; // Soft reset control
	// Power management control fields, and the ready bit of hardware config
	localparam int READY_BIT = 0;
	localparam int PIN_EN_BIT = 1;
	localparam int POL_BIT = 2;
	localparam int IND_BIT = 3;
	localparam int LAN_STS_BIT = 5;
	localparam int BUF_TYPE_BIT = 6;
	localparam int LAN_EN_BIT = 9;
	localparam int ENERGY_DETECT_ENABLE_P1_BIT = 14;
	localparam int ENERGY_DETECT_ENABLE_P2_BIT = 15;
	localparam int HW_READY_BIT = 27;
	// Interrupt status fields
	localparam int IRQ_WAKE_BIT = 0;
	localparam int IRQ_READY_BIT = 1;
	localparam int IRQ_W = 2;
	// Control register fields
	localparam int SOFT_RST_BIT = 0;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int PULSE_MS = 50;
	localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
	localparam int SETTLE_CYC = 16;
endpackage

// [design/wake_event_output_and_ready.sv]
// Wake event output driver, power management control register and ready flag.
// Assumes wake and energy-detect event levels come from other clock domains.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns

module wake_event_output_and_ready import wake_pkg::*; #(
	parameter int PULSE_CYCLES = PULSE_CYC, // 50 ms at 25 MHz
	parameter int SETTLE_CYCLES = SETTLE_CYC // Time to stabilise after reset
) (
	input wire logic clock, // System clock, 25 MHz
	input wire logic hardware_reset_pin, // Hardware reset, active low
	input wire logic [8:0] addr, // Register byte address
	input wire logic [31:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	output logic [31:0] rdata, // Read data, cycle after strobe
	input wire logic lan_wake_evt, // Host MAC wake frame or magic packet level
	input wire logic energy_det_p1, // Port 1 energy detect level
	input wire logic energy_det_p2, // Port 2 energy detect level
	input wire logic digital_reset, // Chip digital reset request, same domain
	output logic wake_out_o, // Wake pin output value
	output logic wake_out_oe, // Wake pin output enable
	output logic irq // Interrupt, active high level
);
	localparam int PW = $clog2(PULSE_CYCLES + 1); // Pulse counter width
	localparam int SW = $clog2(SETTLE_CYCLES + 1); // Settle counter width

	// Synchronisers for asynchronous event levels
	logic [2:0] evt_meta_ff; // First stage, read only by second
	logic [2:0] evt_sync_ff; // Second stage, usable
	logic [2:0] evt_prev_ff; // For edge detection
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			evt_meta_ff <= 3'h0;
			evt_sync_ff <= 3'h0;
			evt_prev_ff <= 3'h0;
		end else begin
			evt_meta_ff <= {energy_det_p2, energy_det_p1, lan_wake_evt};
			evt_sync_ff <= evt_meta_ff;
			evt_prev_ff <= evt_sync_ff;
		end
	end

	// Control bits
	logic buf_type_ff; // 1 push-pull, 0 open-drain
	logic polarity_ff; // 1 active high
	logic ind_style_ff; // 1 pulsed
	logic pin_en_ff; // External pin enable
	logic lan_en_ff; // Lan wake source enable
	logic ed1_en_ff; // Port 1 energy detect enable
	logic ed2_en_ff; // Port 2 energy detect enable
	logic lan_sts_ff; // Sticky lan wake status
	logic ready_ff; // Device ready
	logic [SW-1:0] settle_ff; // Settle countdown
	logic soft_rst_ff; // One-cycle soft reset pulse
	logic [IRQ_W-1:0] irq_sts_ff; // Sticky interrupt status
	logic [IRQ_W-1:0] irq_mask_ff; // Interrupt mask
	logic active_ff; // Wake indication active
	logic [PW-1:0] pulse_ff; // Pulse countdown

	// Decode, writes ignored until ready
	wire wr_ok = wr_stb & ready_ff;
	wire wr_pm = wr_ok && (addr == PWR_MGMT_OFS);
	wire wr_sts = wr_ok && (addr == IRQ_STS_OFS);
	wire wr_mask = wr_ok && (addr == IRQ_MASK_OFS);
	wire wr_ctrl = wr_ok && (addr == CTRL_OFS);
	wire sys_rst = soft_rst_ff | digital_reset; // Register-clearing resets

	// Event detection
	wire lan_level = evt_sync_ff[0];
	wire [2:0] evt_rise = evt_sync_ff & ~evt_prev_ff;
	wire lan_rise = evt_rise[0];
	// Each enabled source counts as a wake event
	wire wake_evt = (lan_rise & lan_en_ff) | (evt_rise[1] & ed1_en_ff)
		| (evt_rise[2] & ed2_en_ff);
	wire sts_clr = wr_pm & wdata[LAN_STS_BIT];
	// Status follows source; clear only takes effect once source is gone
	wire nxt_lan_sts = lan_rise | (lan_sts_ff & ~(sts_clr & ~lan_level));

	// Deactivate on status clear or on any source enable being written from 1 to 0
	wire lan_drop = lan_sts_ff & ~nxt_lan_sts;
	wire en_drop = wr_pm & ((lan_en_ff & ~wdata[LAN_EN_BIT])
		| (ed1_en_ff & ~wdata[ENERGY_DETECT_ENABLE_P1_BIT]) | (ed2_en_ff & ~wdata[ENERGY_DETECT_ENABLE_P2_BIT]));
	wire deact = lan_drop | en_drop;

	// Ready rising edge
	wire ready_rise = (settle_ff == SW'(1)); // Counter about to expire

	// Soft-reset-exempt bits: only hardware reset clears them
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			buf_type_ff <= 1'b0;
			polarity_ff <= 1'b0;
		end else if (wr_pm) begin
			buf_type_ff <= wdata[BUF_TYPE_BIT];
			polarity_ff <= wdata[POL_BIT];
		end
	end

	// Ordinary control bits, cleared by soft or digital reset
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			{ind_style_ff, pin_en_ff, lan_en_ff, ed1_en_ff, ed2_en_ff} <= 5'h00;
			lan_sts_ff <= 1'b0;
		end else if (sys_rst) begin
			{ind_style_ff, pin_en_ff, lan_en_ff, ed1_en_ff, ed2_en_ff} <= 5'h00;
			lan_sts_ff <= 1'b0;
		end else begin
			lan_sts_ff <= nxt_lan_sts;
			if (wr_pm) begin
				ind_style_ff <= wdata[IND_BIT];
				pin_en_ff <= wdata[PIN_EN_BIT];
				lan_en_ff <= wdata[LAN_EN_BIT];
				ed1_en_ff <= wdata[ENERGY_DETECT_ENABLE_P1_BIT];
				ed2_en_ff <= wdata[ENERGY_DETECT_ENABLE_P2_BIT];
			end
		end
	end

	// Soft reset pulse, self-clearing
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin)
			soft_rst_ff <= 1'b0;
		else
			soft_rst_ff <= wr_ctrl & wdata[SOFT_RST_BIT];
	end

	// Ready: held low during any reset, set after settle count
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			ready_ff <= 1'b0;
			settle_ff <= SW'(SETTLE_CYCLES);
		end else if (sys_rst) begin
			ready_ff <= 1'b0;
			settle_ff <= SW'(SETTLE_CYCLES);
		end else if (settle_ff != '0) begin
			settle_ff <= settle_ff - SW'(1);
			ready_ff <= ready_rise;
		end
	end

	// Interrupt status: set wins over write-one clear
	wire [IRQ_W-1:0] irq_set;
	assign irq_set[IRQ_WAKE_BIT] = wake_evt;
	assign irq_set[IRQ_READY_BIT] = ready_rise & ~sys_rst;
	wire [IRQ_W-1:0] irq_clr = wr_sts ? wdata[IRQ_W-1:0] : '0;
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			irq_sts_ff <= '0;
			irq_mask_ff <= '0;
		end else if (sys_rst) begin
			irq_sts_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			irq_sts_ff <= irq_set | (irq_sts_ff & ~irq_clr);
			if (wr_mask)
				irq_mask_ff <= wdata[IRQ_W-1:0];
		end
	end

	// Interrupt output straight from flip-flop
	wire nxt_irq = |(irq_sts_ff & irq_mask_ff);
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin)
			irq <= 1'b0;
		else
			irq <= nxt_irq;
	end

	// Indication state: static latches, pulse counts down, restart on new event
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			active_ff <= 1'b0;
			pulse_ff <= '0;
		end else if (sys_rst | deact) begin
			active_ff <= 1'b0;
			pulse_ff <= '0;
		end else if (wake_evt) begin
			active_ff <= 1'b1;
			pulse_ff <= PW'(PULSE_CYCLES);
		end else if (ind_style_ff && active_ff) begin
			// Pulse mode times out; static stays until deactivated
			pulse_ff <= pulse_ff - PW'(1);
			if (pulse_ff == PW'(1))
				active_ff <= 1'b0;
		end
	end

	// Pin driver selection
	wire assert_pin = active_ff & pin_en_ff;
	// Open-drain: pull low while asserted, float otherwise
	wire od_oe = assert_pin;
	// Push-pull: always driven, level from polarity
	// Active drives the polarity level, idle drives its inverse
	// Polarity only matters here; open-drain ignores it
	wire pp_val = assert_pin ~^ polarity_ff;
	wire nxt_o = buf_type_ff ? pp_val : 1'b0;
	wire nxt_oe = buf_type_ff ? 1'b1 : od_oe;
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin) begin
			wake_out_o <= 1'b0;
			wake_out_oe <= 1'b0; // Float until configured
		end else begin
			wake_out_o <= nxt_o;
			wake_out_oe <= nxt_oe;
		end
	end

	// Read mux; unmapped addresses read zero
	logic [31:0] pm_word; // Assembled control word
	always_comb begin
		pm_word = 32'h0000_0000;
		pm_word[READY_BIT] = ready_ff;
		pm_word[PIN_EN_BIT] = pin_en_ff;
		pm_word[POL_BIT] = polarity_ff;
		pm_word[IND_BIT] = ind_style_ff;
		pm_word[LAN_STS_BIT] = lan_sts_ff;
		pm_word[BUF_TYPE_BIT] = buf_type_ff;
		pm_word[LAN_EN_BIT] = lan_en_ff;
		pm_word[ENERGY_DETECT_ENABLE_P1_BIT] = ed1_en_ff;
		pm_word[ENERGY_DETECT_ENABLE_P2_BIT] = ed2_en_ff;
	end
	// Hardware config holds only the ready mirror here
	wire [31:0] hw_word = {4'h0, ready_ff, 27'h0000000};
	wire [31:0] nxt_rdata =
		(addr == PWR_MGMT_OFS) ? pm_word :
		(addr == HARDWARE_CONFIG_REG_OFS) ? hw_word :
		(addr == IRQ_STS_OFS) ? {30'h0, irq_sts_ff} :
		(addr == IRQ_MASK_OFS) ? {30'h0, irq_mask_ff} :
		(addr == CTRL_OFS) ? {31'h0, soft_rst_ff} : 32'h0000_0000;
	// Reads work before ready so the host can poll; data stands one cycle
	always_ff @(posedge clock or negedge hardware_reset_pin) begin
		if (!hardware_reset_pin)
			rdata <= 32'h0000_0000;
		else
			rdata <= rd_stb ? nxt_rdata : 32'h0000_0000;
	end

	// Checks
	// Ready copy in hardware config reads back what the flag held
	chk_ready_mirror: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(rd_stb && addr == HARDWARE_CONFIG_REG_OFS) |=> rdata[HW_READY_BIT] == $past(ready_ff))
		else $error("ready mirror differs");
	// Any register-clearing reset drops ready
	chk_ready_reset: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		sys_rst |=> !ready_ff)
		else $error("ready not cleared by reset");
	// Early writes must not touch even the exempt bits
	chk_write_gate: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(wr_stb && !ready_ff && addr == PWR_MGMT_OFS)
		|=> $stable({buf_type_ff, polarity_ff, pin_en_ff}))
		else $error("write accepted before ready");
	// Ready rising always leaves its status bit behind
	chk_ready_irq: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		$rose(ready_ff) |-> irq_sts_ff[IRQ_READY_BIT])
		else $error("ready status not set");
	// Unmasked ready status raises the line
	chk_irq_raise: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(irq_sts_ff[IRQ_READY_BIT] && irq_mask_ff[IRQ_READY_BIT]) |=> irq)
		else $error("ready interrupt missing");
	// Soft and digital reset leave the exempt bits alone
	chk_exempt_keep: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(sys_rst && !wr_pm) |=> ($stable(buf_type_ff) && $stable(polarity_ff)))
		else $error("exempt bit lost in reset");

	// Open-drain never drives high
	chk_od_low: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(!buf_type_ff && $past(!buf_type_ff)) |-> !wake_out_o)
		else $error("open drain drove high");
	// Open-drain sinks low while asserted
	chk_od_sink: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(!$past(buf_type_ff) && $past(assert_pin)) |-> (wake_out_oe && !wake_out_o))
		else $error("open drain not sinking");
	// Open-drain lets go of the net when idle
	chk_od_float: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(!$past(buf_type_ff) && !$past(assert_pin)) |-> !wake_out_oe)
		else $error("open drain not floating");
	// Disabled open-drain pin stays off the net
	chk_pin_gate: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(!pin_en_ff && !buf_type_ff) |=> !wake_out_oe)
		else $error("disabled pin asserted");
	// Push-pull always drives the net
	chk_pp_drive: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		$past(buf_type_ff) |-> wake_out_oe)
		else $error("push pull not driving");
	// Push-pull active level follows polarity
	chk_pp_active: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		($past(buf_type_ff) && $past(assert_pin)) |-> wake_out_o == $past(polarity_ff))
		else $error("active level wrong");
	// Push-pull idle level is the opposite one
	chk_pp_idle: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		($past(buf_type_ff) && !$past(assert_pin)) |-> wake_out_o != $past(polarity_ff))
		else $error("idle level wrong");

	// Events flag an interrupt whatever the pin enable
	chk_irq_nogate: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(wake_evt && !sys_rst) |=> irq_sts_ff[IRQ_WAKE_BIT])
		else $error("wake event lost");
	// Port 1 energy detect flags like lan wake
	chk_ed_irq: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(evt_rise[1] && ed1_en_ff && !sys_rst) |=> irq_sts_ff[IRQ_WAKE_BIT])
		else $error("energy detect lost");
	// Enabled lan wake starts the indication
	chk_lan_activate: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(lan_rise && lan_en_ff && !sys_rst && !deact) |=> active_ff)
		else $error("lan wake not indicated");
	// Lan wake rise sets the sticky status
	chk_lan_set: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(lan_rise && !sys_rst) |=> lan_sts_ff)
		else $error("lan status not set");
	// Status survives a clear while the source lives
	chk_sts_hold: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(lan_sts_ff && lan_level && !sys_rst) |=> lan_sts_ff)
		else $error("status cleared with live source");

	// Event mid-pulse reloads the full count
	chk_pulse_restart: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(wake_evt && !sys_rst && !deact) |=> (active_ff && pulse_ff == PW'(PULSE_CYCLES)))
		else $error("pulse not restarted");
	// Pulse ends when the count runs out
	chk_pulse_end: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(ind_style_ff && active_ff && pulse_ff == PW'(1) && !wake_evt) |=> !active_ff)
		else $error("pulse overran");
	// Static style holds until deactivated
	chk_static_hold: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		(!ind_style_ff && active_ff && !deact && !sys_rst) |=> active_ff)
		else $error("static indication dropped");
	// Deactivation drops the indication next cycle and floats an open-drain pin the cycle after
	chk_deact_out: assert property (@(posedge clock) disable iff (!hardware_reset_pin)
		deact |=> !active_ff ##1 ($past(buf_type_ff) || !wake_out_oe))
		else $error("output not deactivated");
endmodule // wake_event_output_and_ready

// [testbench/wake_sense_model.sv]
// Model of the external power controller that senses the wake net.
// Assumes a board pull-up on the net, so a released pin reads high.
`timescale 1ns/1ns
module wake_sense_model (
	input wire logic pin_o, // Level driven by the block
	input wire logic pin_oe, // Drive enable of the block
	output logic pin // Resolved level of the wake net
);
	// Pull-up wins whenever the block lets go of the net
	assign pin = pin_oe ? pin_o : 1'b1;
endmodule // wake_sense_model

// [testbench/wake_event_output_and_ready_test.sv]
// Self-checking bench for the wake output, control register and ready flag.
// Assumes the register port of the block and a pulled-up wake net.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module wake_event_output_and_ready_test import wake_pkg::*;;
	localparam int PC = 20; // Short pulse keeps the run brief
	logic clock = 1'b0;
	logic hardware_reset_pin = 1'b0;
	logic [8:0] addr = 9'h000;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'b0, rd_stb = 1'b0, drst = 1'b0;
	logic lan_evt = 1'b0, ed1 = 1'b0, ed2 = 1'b0;
	logic [31:0] rdata, d, w, seed = 32'h28;
	logic wo, woe, irq, pin, pp, pol;
	int fails = 0, cmp_count = 0, len;
	wake_event_output_and_ready #(.PULSE_CYCLES(PC), .SETTLE_CYCLES(16)) i_wake_event_output_and_ready (
		.clock(clock), .hardware_reset_pin(hardware_reset_pin), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .lan_wake_evt(lan_evt), .energy_det_p1(ed1), .energy_det_p2(ed2),
		.digital_reset(drst), .wake_out_o(wo), .wake_out_oe(woe), .irq(irq));
	wake_sense_model i_wake_sense_model (.pin_o(wo), .pin_oe(woe), .pin(pin));
	// Free-running 25 MHz clock
	initial begin
		forever #20 clock = ~clock;
	end
	// Xorshift source, fixed start
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Control word from its fields
	function automatic logic [31:0] cfg(input logic t, p, ind, en, lan, e1, e2);
		return 32'(t) << BUF_TYPE_BIT | 32'(p) << POL_BIT | 32'(ind) << IND_BIT | 32'(en) << PIN_EN_BIT
			| 32'(lan) << LAN_EN_BIT | 32'(e1) << ENERGY_DETECT_ENABLE_P1_BIT | 32'(e2) << ENERGY_DETECT_ENABLE_P2_BIT;
	endfunction
	// Net level the controller should see
	function automatic logic exp_pin(input logic act, t, p);
		return act ? (t ? p : 1'b0) : (t ? ~p : 1'b1);
	endfunction
	// One-cycle register write
	task automatic wr(input logic [8:0] a, input logic [31:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	// One-cycle read, data sampled in the following cycle
	task automatic rd(input logic [8:0] a);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask
	// Poll until settled, bounded; only the control word is touched meanwhile
	task automatic wait_ready();
		for (int i = 0; i < 40; i++) begin
			rd(PWR_MGMT_OFS);
			if (d[READY_BIT] === 1'b1) break;
		end
	endtask
	// Length of an active-high pulse, optional second event mid-pulse
	task automatic measure(input int kick);
		len = 0;
		while (pin !== 1'b1 && len < 20) begin
			@(posedge clock);
			#1 len++;
		end
		len = 0;
		while (pin === 1'b1 && len < 100) begin
			@(posedge clock);
			#1 len++;
			if (len == kick) ed2 <= 1'b1;
		end
	endtask
	// Verdict, the single end of the run
	task automatic summarize();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#(40 * 20000);
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		hardware_reset_pin <= 1'b1;
		rd(PWR_MGMT_OFS);
		`CHK(d[READY_BIT], 1'b0)
		wr(PWR_MGMT_OFS, cfg(1, 1, 0, 1, 1, 0, 0));
		wait_ready();
		`CHK(d[PIN_EN_BIT], 1'b0)
		rd(HARDWARE_CONFIG_REG_OFS);
		`CHK(d[HW_READY_BIT], 1'b1)
		wr(IRQ_MASK_OFS, 32'h2);
		repeat (3) @(posedge clock);
		`CHK(irq, 1'b1)
		wr(IRQ_STS_OFS, 32'h3);
		repeat (3) @(posedge clock);
		`CHK(irq, 1'b0)
		// Random mask traffic, then an unmapped read
		repeat (4) begin
			w = xs();
			wr(IRQ_MASK_OFS, w);
			rd(IRQ_MASK_OFS);
			`CHK(d, w & 32'h3)
		end
		rd(9'h1f0);
		`CHK(d, 32'h0)
		wr(IRQ_MASK_OFS, 32'h1);
		// Every driver type and polarity, static style, lan source
		for (int k = 0; k < 4; k++) begin
			{pp, pol} = 2'(k);
			wr(PWR_MGMT_OFS, cfg(pp, pol, 0, 1, 1, 0, 0));
			repeat (2) @(posedge clock);
			`CHK(pin, exp_pin(0, pp, pol))
			`CHK(woe, pp)
			lan_evt <= 1'b1;
			repeat (8) @(posedge clock);
			`CHK(pin, exp_pin(1, pp, pol))
			`CHK(irq, 1'b1)
			wr(PWR_MGMT_OFS, cfg(pp, pol, 0, 1, 1, 0, 0) | 32'h20);
			rd(PWR_MGMT_OFS);
			`CHK(d[LAN_STS_BIT], 1'b1)
			lan_evt <= 1'b0; // Source goes away before the clear
			repeat (4) @(posedge clock);
			wr(PWR_MGMT_OFS, cfg(pp, pol, 0, 1, 1, 0, 0) | 32'h20);
			wr(IRQ_STS_OFS, 32'h1);
			repeat (3) @(posedge clock);
			`CHK(pin, exp_pin(0, pp, pol))
		end
		// Pin disabled: net idle, flag still raised
		wr(PWR_MGMT_OFS, cfg(0, 0, 0, 0, 1, 0, 0));
		lan_evt <= 1'b1;
		repeat (8) @(posedge clock);
		`CHK(woe, 1'b0)
		`CHK(irq, 1'b1)
		lan_evt <= 1'b0;
		wr(IRQ_STS_OFS, 32'h1);
		// Pulse from port 1, then a restart from port 2
		wr(PWR_MGMT_OFS, cfg(1, 1, 1, 1, 0, 1, 1));
		repeat (2) @(posedge clock); // New driver type must reach the net first
		ed1 <= 1'b1;
		measure(0);
		`CHK(len, PC)
		ed1 <= 1'b0;
		repeat (4) @(posedge clock);
		ed1 <= 1'b1;
		measure(10);
		`CHK(len > PC + 10 && len <= PC + 18, 1'b1)
		// Soft reset, then digital reset: exempt bits survive
		wr(CTRL_OFS, 32'h1);
		@(posedge clock); // Reset pulse lands one cycle after the write
		rd(PWR_MGMT_OFS);
		`CHK(d[READY_BIT], 1'b0)
		wait_ready();
		`CHK({d[BUF_TYPE_BIT], d[POL_BIT], d[ENERGY_DETECT_ENABLE_P1_BIT]}, 3'b110)
		@(posedge clock);
		drst <= 1'b1;
		@(posedge clock);
		drst <= 1'b0;
		rd(HARDWARE_CONFIG_REG_OFS);
		`CHK(d[HW_READY_BIT], 1'b0)
		wait_ready();
		`CHK({d[BUF_TYPE_BIT], d[POL_BIT], d[READY_BIT]}, 3'b111)
		summarize();
	end
endmodule // wake_event_output_and_ready_test
